// *** core/exec_guard.sv ***
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module exec_guard
	import mem_order_pkg::*;
(
	input  wire logic              CORE_CLK,                // Core clock
	input  wire logic              RST,                     // Async reset, high
	input  wire logic              CE,                      // Clock enable
	input  wire logic [11:0]       AWADDR,                  // AXI write address
	input  wire logic              AWVALID,                 // AXI write address valid
	output logic                   AWREADY,                 // AXI write address ready
	input  wire logic [31:0]       WDATA,                   // AXI write data
	input  wire logic [3:0]        WSTRB,                   // AXI byte strobes
	input  wire logic              WVALID,                  // AXI write data valid
	output logic                   WREADY,                  // AXI write data ready
	output logic [1:0]             BRESP,                   // AXI write response
	output logic                   BVALID,                  // AXI write response valid
	input  wire logic              BREADY,                  // AXI write response ready
	input  wire logic [11:0]       ARADDR,                  // AXI read address
	input  wire logic              ARVALID,                 // AXI read address valid
	output logic                   ARREADY,                 // AXI read address ready
	output logic [31:0]            RDATA,                   // AXI read data
	output logic [1:0]             RRESP,                   // AXI read response
	output logic                   RVALID,                  // AXI read data valid
	input  wire logic              RREADY,                  // AXI read data ready
	input  wire logic              ACC_VALID,               // Core access request
	input  wire logic [2:0]        ACC_KIND,                // Access kind code
	input  wire logic [ADDR_W-1:0] ACC_ADDR,                // Access address
	input  wire logic [DATA_W-1:0] ACC_WDATA,               // Write data
	input  wire logic              ACC_PRIV,                // Privileged access
	input  wire logic              ACC_EXCL,                // Exclusive access
	output logic                   ACC_BUSY,                // Access outstanding
	output logic                   ACC_DONE,                // Access complete pulse
	output logic [DATA_W-1:0]      ACC_RDATA,               // Read data with done
	output logic                   ACC_EXCL_FAIL,           // Exclusive store failed
	output logic                   ACC_IS_READ,             // Last access classed as read
	output logic                   ACC_IS_WRITE,            // Last access classed as write
	output logic                   ACC_EXPLICIT,            // Last access was explicit
	output logic                   MEMORY_MANAGEMENT_FAULT, // Fault pulse
	output logic                   FAULT_ON_FETCH,          // Last fault was a fetch
	output logic                   IRQ,                     // Level interrupt
	mem_link_if.dev                link                     // Link to memory side
);
	typedef struct packed {
		logic                                ctrl_en;
		logic [ST_W-1:0]                     status;
		logic [ST_W-1:0]                     mask;
		logic [ADDR_W-1:0]                   fault_addr;
		logic [NUM_REGIONS-1:0][ATTR_W-1:0]  attr;
		logic                                irq;
		logic                                w_rdy;
		logic                                bvalid;
		logic [1:0]                          bresp;
		logic                                ar_rdy;
		logic                                rvalid;
		logic [1:0]                          rresp;
		logic [31:0]                         rdata;
		logic                                busy;
		logic                                gobs_seen;
		logic                                done;
		logic [DATA_W-1:0]                   acc_rdata;
		logic                                excl_fail;
		logic                                is_read;
		logic                                is_write;
		logic                                explicit;
		logic                                fault;
		logic                                fault_fetch;
		logic                                l_valid;
		logic [ADDR_W-1:0]                   l_addr;
		logic                                l_write;
		logic [DATA_W-1:0]                   l_wdata;
		logic                                l_share;
		logic                                l_strong;
		logic                                l_excl;
		logic                                l_maint;
	} gstate_t;

	gstate_t                s_ff;
	gstate_t                nxt_s;
	logic [ATTR_W-1:0]      attr;
	exec_level_t            xl;
	logic                   rd;
	logic                   wr;
	logic                   expl;
	logic                   exec_fault;
	logic                   data_fault;
	logic [ST_W-1:0]        st_set;
	logic [ST_W-1:0]        st_clr;
	logic [2:0]             region;

	// Access classification and permission checks
	always_comb
	begin
		region = ACC_ADDR[REGION_SEL_LSB+:3];
		// Default map keeps execute control alive with protection off
		attr = s_ff.ctrl_en ? s_ff.attr[region] : DEFAULT_MAP[region];
		xl = exec_level(attr);
		rd = 1'b0;
		wr = 1'b0;
		expl = 1'b0;
		exec_fault = 1'b0;
		unique case (ACC_KIND)
			KIND_FETCH:
				// Privileged-only execution needs a privileged fetch
				exec_fault = xl == XL_NONE || (xl == XL_PRIV && !ACC_PRIV);
			KIND_LOAD:
			begin
				rd = 1'b1;
				expl = 1'b1;
			end
			KIND_STORE:
			begin
				wr = 1'b1;
				rd = ACC_EXCL;
				expl = 1'b1;
			end
			KIND_TABLE:
			begin
				rd = 1'b1;
				expl = 1'b1;
			end
			KIND_LINEFILL, KIND_WRITEBACK, KIND_MAINT:
				expl = 1'b0;
			default:
				expl = 1'b0;
		endcase
		// Data rights only apply while protection is enabled
		data_fault = s_ff.ctrl_en && expl &&
			(attr[AP_LSB+:2] == AP_NONE || (attr[AP_LSB+:2] == AP_PRIV && !ACC_PRIV));
	end

	// Next state: core side, link side, register bus
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		nxt_s.fault = 1'b0;
		st_set = '0;
		st_clr = '0;
		if (ACC_VALID && !s_ff.busy)
		begin
			nxt_s.is_read = rd;
			nxt_s.is_write = wr;
			nxt_s.explicit = expl;
			if (exec_fault || data_fault)
			begin
				// Nothing is forwarded, so the access never takes effect
				nxt_s.fault = 1'b1;
				nxt_s.fault_fetch = exec_fault;
				nxt_s.fault_addr = ACC_ADDR;
				st_set[ST_EXEC_FAULT] = exec_fault;
				st_set[ST_DATA_FAULT] = data_fault;
			end
			else
			begin
				nxt_s.busy = 1'b1;
				nxt_s.gobs_seen = 1'b0;
				nxt_s.l_valid = 1'b1;
				nxt_s.l_addr = ACC_ADDR;
				nxt_s.l_write = wr || ACC_KIND == KIND_WRITEBACK;
				nxt_s.l_wdata = ACC_WDATA;
				nxt_s.l_share = attr[SHARE_BIT];
				nxt_s.l_strong = attr[STRONG_BIT];
				nxt_s.l_excl = ACC_EXCL && expl;
				nxt_s.l_maint = ACC_KIND == KIND_MAINT;
			end
		end
		if (s_ff.busy && link.rsp_gobs)
			nxt_s.gobs_seen = 1'b1;
		// Completion only counts after global observation
		if (s_ff.busy && link.rsp_done && (s_ff.gobs_seen || link.rsp_gobs))
		begin
			nxt_s.busy = 1'b0;
			nxt_s.l_valid = 1'b0;
			nxt_s.done = 1'b1;
			nxt_s.acc_rdata = link.rsp_rdata;
			nxt_s.excl_fail = link.rsp_excl_fail;
			st_set[ST_DONE] = 1'b1;
		end

		// Write channel: both ready together once address and data wait
		if (!s_ff.w_rdy && !s_ff.bvalid && AWVALID && WVALID)
			nxt_s.w_rdy = 1'b1;
		if (s_ff.w_rdy && AWVALID && WVALID)
		begin
			nxt_s.w_rdy = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = RESP_OKAY;
			if (AWADDR == REG_CTRL)
			begin
				if (WSTRB[0])
					nxt_s.ctrl_en = WDATA[0];
			end
			else if (AWADDR == REG_STATUS)
			begin
				if (WSTRB[0])
					st_clr = WDATA[ST_W-1:0];
			end
			else if (AWADDR == REG_MASK)
			begin
				if (WSTRB[0])
					nxt_s.mask = WDATA[ST_W-1:0];
			end
			else if (AWADDR == REG_FAULT_ADDR || AWADDR == REG_SIDE)
				nxt_s.bresp = RESP_OKAY;
			else if (AWADDR[11:5] == REG_REGION_BASE[11:5] && AWADDR[1:0] == 2'h0)
			begin
				if (WSTRB[0])
					nxt_s.attr[AWADDR[4:2]] = WDATA[ATTR_W-1:0];
			end
			else
				nxt_s.bresp = RESP_SLVERR;
		end
		if (s_ff.bvalid && BREADY)
			nxt_s.bvalid = 1'b0;

		// Read channel
		if (!s_ff.ar_rdy && !s_ff.rvalid && ARVALID)
			nxt_s.ar_rdy = 1'b1;
		if (s_ff.ar_rdy && ARVALID)
		begin
			nxt_s.ar_rdy = 1'b0;
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp = RESP_OKAY;
			nxt_s.rdata = '0;
			if (ARADDR == REG_CTRL)
				nxt_s.rdata[0] = s_ff.ctrl_en;
			else if (ARADDR == REG_STATUS)
				nxt_s.rdata[ST_W-1:0] = s_ff.status;
			else if (ARADDR == REG_MASK)
				nxt_s.rdata[ST_W-1:0] = s_ff.mask;
			else if (ARADDR == REG_FAULT_ADDR)
				nxt_s.rdata = s_ff.fault_addr;
			else if (ARADDR == REG_SIDE)
				nxt_s.rdata[0] = link.rsp_side_pending;
			else if (ARADDR[11:5] == REG_REGION_BASE[11:5] && ARADDR[1:0] == 2'h0)
				nxt_s.rdata[ATTR_W-1:0] = s_ff.attr[ARADDR[4:2]];
			else
				nxt_s.rresp = RESP_SLVERR;
		end
		if (s_ff.rvalid && RREADY)
			nxt_s.rvalid = 1'b0;

		// Sticky status: a new event wins over a same-cycle clear
		nxt_s.status = (s_ff.status & ~st_clr) | st_set;
		nxt_s.irq = |(nxt_s.status & nxt_s.mask);
	end

	// State register; region table resets to the default map
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
		begin
			s_ff <= '0;
			s_ff.ctrl_en <= CTRL_RESET;
			s_ff.status <= STATUS_RESET;
			s_ff.mask <= MASK_RESET;
			s_ff.attr <= DEFAULT_MAP;
		end
		else if (CE)
			s_ff <= nxt_s;
	end

	assign AWREADY = s_ff.w_rdy;
	assign WREADY = s_ff.w_rdy;
	assign BRESP = s_ff.bresp;
	assign BVALID = s_ff.bvalid;
	assign ARREADY = s_ff.ar_rdy;
	assign RDATA = s_ff.rdata;
	assign RRESP = s_ff.rresp;
	assign RVALID = s_ff.rvalid;
	assign ACC_BUSY = s_ff.busy;
	assign ACC_DONE = s_ff.done;
	assign ACC_RDATA = s_ff.acc_rdata;
	assign ACC_EXCL_FAIL = s_ff.excl_fail;
	assign ACC_IS_READ = s_ff.is_read;
	assign ACC_IS_WRITE = s_ff.is_write;
	assign ACC_EXPLICIT = s_ff.explicit;
	assign MEMORY_MANAGEMENT_FAULT = s_ff.fault;
	assign FAULT_ON_FETCH = s_ff.fault_fetch;
	assign IRQ = s_ff.irq;
	assign link.req_valid = s_ff.l_valid;
	assign link.req_addr = s_ff.l_addr;
	assign link.req_write = s_ff.l_write;
	assign link.req_wdata = s_ff.l_wdata;
	assign link.req_explicit = s_ff.explicit;
	assign link.req_share = s_ff.l_share;
	assign link.req_strong = s_ff.l_strong;
	assign link.req_excl = s_ff.l_excl;
	assign link.req_maint = s_ff.l_maint;
endmodule

// *** core/mem_completion.sv ***
`timescale 1ns/1ps
module mem_completion
	import mem_order_pkg::*;
(
	input  wire logic              CORE_CLK,     // Core clock
	input  wire logic              RST,          // Async reset, high
	input  wire logic              CE,           // Clock enable
	mem_link_if.mem                link,         // Link from the guard
	output logic                   SYS_VALID,    // Access to memory or peripheral
	output logic [ADDR_W-1:0]      SYS_ADDR,     // Access address
	output logic                   SYS_WRITE,    // Access is a write
	output logic [DATA_W-1:0]      SYS_WDATA,    // Write data
	output logic                   SYS_STRONG,   // Strongly-ordered access
	input  wire logic              SYS_ACK,      // Access now affects target state
	input  wire logic [DATA_W-1:0] SYS_RDATA,    // Read data with ack
	input  wire logic              FETCH_SYNCED, // Fetch observers have seen it
	input  wire logic              SIDE_VISIBLE, // Side effects now visible
	output logic                   SIDE_PENDING  // Pollable side-effect status
);
	typedef struct packed {
		mem_state_t          st;
		logic                sys_valid;
		logic [ADDR_W-1:0]   sys_addr;
		logic                sys_write;
		logic [DATA_W-1:0]   sys_wdata;
		logic                sys_strong;
		logic                obs;
		logic                gobs;
		logic                done;
		logic [DATA_W-1:0]   rdata;
		logic                excl_fail;
		logic                lmon_valid;
		logic [ADDR_W-3:0]   lmon_addr;
		logic                gmon_valid;
		logic [ADDR_W-3:0]   gmon_addr;
		logic                side_pending;
	} mstate_t;

	mstate_t s_ff;
	mstate_t nxt_s;
	logic    mon_hit;

	// Exclusive monitor match for the held request
	always_comb
	begin
		if (link.req_share)
			mon_hit = s_ff.gmon_valid && s_ff.gmon_addr == link.req_addr[ADDR_W-1:2];
		else
			mon_hit = s_ff.lmon_valid && s_ff.lmon_addr == link.req_addr[ADDR_W-1:2];
	end

	// Sequencing: issue, observation, completion
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.obs = 1'b0;
		nxt_s.gobs = 1'b0;
		nxt_s.done = 1'b0;
		unique case (s_ff.st)
			MS_IDLE:
			begin
				// Done guard stops a retake while the guard drops its request
				if (link.req_valid && !s_ff.done)
				begin
					nxt_s.excl_fail = 1'b0;
					if (link.req_maint)
					begin
						nxt_s.obs = 1'b1;
						nxt_s.gobs = 1'b1;
						nxt_s.done = 1'b1;
					end
					else if (link.req_excl && link.req_write && !mon_hit)
					begin
						// Failed exclusive store never reaches memory
						nxt_s.excl_fail = 1'b1;
						nxt_s.obs = 1'b1;
						nxt_s.gobs = 1'b1;
						nxt_s.done = 1'b1;
					end
					else
					begin
						nxt_s.sys_valid = 1'b1;
						nxt_s.sys_addr = link.req_addr;
						nxt_s.sys_write = link.req_write;
						nxt_s.sys_wdata = link.req_wdata;
						nxt_s.sys_strong = link.req_strong;
						nxt_s.st = MS_ISSUE;
					end
				end
			end
			MS_ISSUE:
			begin
				// Ack means the target state can change and side effects fire
				if (SYS_ACK)
				begin
					nxt_s.sys_valid = 1'b0;
					nxt_s.rdata = SYS_RDATA;
					nxt_s.obs = 1'b1;
					nxt_s.gobs = 1'b1;
					nxt_s.st = MS_SYNC;
					if (link.req_excl && !link.req_write)
					begin
						if (link.req_share)
						begin
							nxt_s.gmon_valid = 1'b1;
							nxt_s.gmon_addr = link.req_addr[ADDR_W-1:2];
						end
						else
						begin
							nxt_s.lmon_valid = 1'b1;
							nxt_s.lmon_addr = link.req_addr[ADDR_W-1:2];
						end
					end
					else if (link.req_write)
					begin
						// Any write to a watched word ends the reservation
						if (s_ff.lmon_addr == link.req_addr[ADDR_W-1:2] || link.req_excl)
							nxt_s.lmon_valid = 1'b0;
						if (s_ff.gmon_addr == link.req_addr[ADDR_W-1:2] || link.req_excl)
							nxt_s.gmon_valid = 1'b0;
					end
				end
			end
			MS_SYNC:
			begin
				// Globally observed already; wait for the fetch side
				if (FETCH_SYNCED)
				begin
					nxt_s.done = 1'b1;
					nxt_s.st = MS_IDLE;
				end
			end
			default:
				nxt_s.st = MS_IDLE;
		endcase
		// Completion alone does not make side effects visible; set wins
		if (s_ff.st == MS_ISSUE && SYS_ACK && link.req_strong)
			nxt_s.side_pending = 1'b1;
		else if (SIDE_VISIBLE)
			nxt_s.side_pending = 1'b0;
	end

	// State register
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
			s_ff <= '0;
		else if (CE)
			s_ff <= nxt_s;
	end

	assign SYS_VALID = s_ff.sys_valid;
	assign SYS_ADDR = s_ff.sys_addr;
	assign SYS_WRITE = s_ff.sys_write;
	assign SYS_WDATA = s_ff.sys_wdata;
	assign SYS_STRONG = s_ff.sys_strong;
	assign SIDE_PENDING = s_ff.side_pending;
	assign link.rsp_obs = s_ff.obs;
	assign link.rsp_gobs = s_ff.gobs;
	assign link.rsp_done = s_ff.done;
	assign link.rsp_rdata = s_ff.rdata;
	assign link.rsp_excl_fail = s_ff.excl_fail;
	assign link.rsp_side_pending = s_ff.side_pending;
endmodule

// *** core/mem_link_if.sv ***
`timescale 1ns/1ps
interface mem_link_if;
	import mem_order_pkg::*;
	logic              req_valid;        // Access held until done
	logic [ADDR_W-1:0] req_addr;         // Byte address
	logic              req_write;        // Store or write-back
	logic [DATA_W-1:0] req_wdata;        // Write data
	logic              req_explicit;     // Subject to ordering
	logic              req_share;        // Shareable region
	logic              req_strong;       // Strongly-ordered region
	logic              req_excl;         // Exclusive access
	logic              req_maint;        // Cache or predictor maintenance
	logic              rsp_obs;          // Observed pulse
	logic              rsp_gobs;         // Globally observed pulse
	logic              rsp_done;         // Complete pulse
	logic [DATA_W-1:0] rsp_rdata;        // Read data with done
	logic              rsp_excl_fail;    // Exclusive store failed
	logic              rsp_side_pending; // Side effects not yet visible

	modport dev (output req_valid, req_addr, req_write, req_wdata, req_explicit, req_share,
		req_strong, req_excl, req_maint,
		input rsp_obs, rsp_gobs, rsp_done, rsp_rdata, rsp_excl_fail, rsp_side_pending);
	modport mem (input req_valid, req_addr, req_write, req_wdata, req_explicit, req_share,
		req_strong, req_excl, req_maint,
		output rsp_obs, rsp_gobs, rsp_done, rsp_rdata, rsp_excl_fail, rsp_side_pending);
endinterface

// *** core/mem_order_pkg.sv ***
package mem_order_pkg;
	// Bus and table geometry
	localparam int ADDR_W         = 32;
	localparam int DATA_W         = 32;
	localparam int NUM_REGIONS    = 8;
	localparam int REGION_SEL_LSB = 29;
	localparam int ATTR_W         = 5;

	// Region attribute fields
	localparam int AP_LSB     = 0;
	localparam int EXEC_BIT   = 2;
	localparam int SHARE_BIT  = 3;
	localparam int STRONG_BIT = 4;
	localparam logic [1:0] AP_NONE = 2'h0;
	localparam logic [1:0] AP_PRIV = 2'h1;

	// Status and mask bits
	localparam int ST_EXEC_FAULT = 0;
	localparam int ST_DATA_FAULT = 1;
	localparam int ST_DONE       = 2;
	localparam int ST_W          = 3;

	// Register byte offsets
	localparam logic [11:0] REG_CTRL        = 12'h000;
	localparam logic [11:0] REG_STATUS      = 12'h004;
	localparam logic [11:0] REG_MASK        = 12'h008;
	localparam logic [11:0] REG_FAULT_ADDR  = 12'h00c;
	localparam logic [11:0] REG_SIDE        = 12'h010;
	localparam logic [11:0] REG_REGION_BASE = 12'h020;

	// Values after reset
	localparam logic            CTRL_RESET   = 1'b0;
	localparam logic [ST_W-1:0] STATUS_RESET = 3'h0;
	localparam logic [ST_W-1:0] MASK_RESET   = 3'h0;
	// Fallback attributes per address slice when protection is off
	localparam logic [NUM_REGIONS-1:0][ATTR_W-1:0] DEFAULT_MAP =
		{5'h11, 5'h0a, 5'h0a, 5'h06, 5'h06, 5'h0a, 5'h06, 5'h06};

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {XL_NONE = 2'b00, XL_PRIV = 2'b01, XL_ALL = 2'b10} exec_level_t;

	typedef enum logic [2:0] {
		KIND_FETCH     = 3'b000,
		KIND_LOAD      = 3'b001,
		KIND_STORE     = 3'b010,
		KIND_TABLE     = 3'b011,
		KIND_LINEFILL  = 3'b100,
		KIND_WRITEBACK = 3'b101,
		KIND_MAINT     = 3'b110
	} kind_t;

	typedef enum logic [1:0] {MS_IDLE = 2'b00, MS_ISSUE = 2'b01, MS_SYNC = 2'b10} mem_state_t;

	// Execution level from read rights plus the execute flag
	function automatic exec_level_t exec_level(input logic [ATTR_W-1:0] attr);
		exec_level_t lvl;
		lvl = XL_ALL;
		if (!attr[EXEC_BIT] || attr[AP_LSB+:2] == AP_NONE)
			lvl = XL_NONE;
		else if (attr[AP_LSB+:2] == AP_PRIV)
			lvl = XL_PRIV;
		return lvl;
	endfunction
endpackage

// *** testbench/exec_permission_and_access_completion_bench.sv ***
`timescale 1ns/1ps
module exec_permission_and_access_completion_bench;
	import mem_order_pkg::*;
	logic        core_clk, rst, awvalid, wvalid, bready, arvalid, rready, acc_valid, acc_priv, acc_excl, flt;
	logic        awready, wready, bvalid, arready, rvalid, acc_busy, acc_done, excl_fail, is_rd, is_wr, is_expl;
	logic        mmf, on_fetch, irq, sys_valid, sys_write, sys_strong, sys_ack, fetch_synced, side_visible, side_pending;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, acc_addr, acc_wdata, acc_rdata, sys_addr, sys_wdata, sys_rdata, rd;
	logic [2:0]  acc_kind;
	logic [1:0]  bresp, rresp, rs;
	int          miscompares, comparisons, n, sys_cnt, c0;
	localparam logic [39:0] attr_tab = {5'h00, 5'h01, 5'h01, 5'h04, 5'h02, 5'h06, 5'h05, 5'h05};
	mem_link_if mem_link_if_inst ();
	exec_guard exec_guard_inst (.CORE_CLK(core_clk), .RST(rst), .CE(1'b1), .AWADDR(awaddr), .AWVALID(awvalid),
		.AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
		.BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
		.RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .ACC_VALID(acc_valid), .ACC_KIND(acc_kind),
		.ACC_ADDR(acc_addr), .ACC_WDATA(acc_wdata), .ACC_PRIV(acc_priv), .ACC_EXCL(acc_excl), .ACC_BUSY(acc_busy),
		.ACC_DONE(acc_done), .ACC_RDATA(acc_rdata), .ACC_EXCL_FAIL(excl_fail), .ACC_IS_READ(is_rd),
		.ACC_IS_WRITE(is_wr), .ACC_EXPLICIT(is_expl), .MEMORY_MANAGEMENT_FAULT(mmf), .FAULT_ON_FETCH(on_fetch),
		.IRQ(irq), .link(mem_link_if_inst));
	mem_completion mem_completion_inst (.CORE_CLK(core_clk), .RST(rst), .CE(1'b1), .link(mem_link_if_inst),
		.SYS_VALID(sys_valid), .SYS_ADDR(sys_addr), .SYS_WRITE(sys_write), .SYS_WDATA(sys_wdata),
		.SYS_STRONG(sys_strong), .SYS_ACK(sys_ack), .SYS_RDATA(sys_rdata), .FETCH_SYNCED(fetch_synced),
		.SIDE_VISIBLE(side_visible), .SIDE_PENDING(side_pending));
	link_properties link_properties_inst (.CORE_CLK(core_clk), .RST(rst), .req_valid(mem_link_if_inst.req_valid),
		.req_addr(mem_link_if_inst.req_addr), .req_write(mem_link_if_inst.req_write),
		.req_explicit(mem_link_if_inst.req_explicit), .req_excl(mem_link_if_inst.req_excl),
		.req_maint(mem_link_if_inst.req_maint), .rsp_obs(mem_link_if_inst.rsp_obs),
		.rsp_gobs(mem_link_if_inst.rsp_gobs), .rsp_done(mem_link_if_inst.rsp_done),
		.rsp_excl_fail(mem_link_if_inst.rsp_excl_fail));
	// Far memory acks one cycle late; read data is the inverted address
	always @(posedge core_clk)
	begin
		sys_ack <= !rst && sys_valid && !sys_ack;
		sys_rdata <= ~sys_addr;
		sys_cnt <= rst ? 0 : sys_cnt + int'(sys_valid && !sys_ack);
	end
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// A wait that ran out of cycles ends the run
	task automatic tmo;
		if (n >= 99)
		begin
			miscompares++;
			summarize();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 99 && !(awready && wready); n++)
			@(negedge core_clk);
		tmo();
		@(posedge core_clk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		for (n = 0; n < 99 && !bvalid; n++)
			@(negedge core_clk);
		tmo();
		chk("write resp", 32'(bresp), 32'(RESP_OKAY));
		@(posedge core_clk);
		bready <= 1'b0;
	endtask
	task automatic rdr(input logic [11:0] a);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 99 && !arready; n++)
			@(negedge core_clk);
		tmo();
		@(posedge core_clk);
		arvalid <= 1'b0;
		for (n = 0; n < 99 && !rvalid; n++)
			@(negedge core_clk);
		tmo();
		rd = rdata;
		rs = rresp;
		@(posedge core_clk);
		rready <= 1'b0;
	endtask
	// Single-cycle request: taken at once because the guard is idle
	task automatic acc(input logic [2:0] k, input logic [31:0] a, input logic p, input logic x);
		c0 = sys_cnt;
		@(posedge core_clk);
		acc_kind <= k;
		acc_addr <= a;
		acc_wdata <= ~a;
		acc_priv <= p;
		acc_excl <= x;
		acc_valid <= 1'b1;
		@(posedge core_clk);
		acc_valid <= 1'b0;
		for (n = 0; n < 99 && !(acc_done || mmf); n++)
			@(negedge core_clk);
		tmo();
		flt = mmf;
	endtask
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, acc_valid, acc_priv, acc_excl, side_visible} = '0;
		{awaddr, araddr, wdata, acc_addr, acc_wdata, acc_kind} = '0;
		{miscompares, comparisons} = '0;
		{fetch_synced, rst} = 2'b11;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		rdr(REG_CTRL);
		chk("ctrl reset", rd, 32'h0);
		rdr(12'hffc);
		chk("unmapped resp", 32'(rs), 32'(RESP_SLVERR));
		// Default map governs fetches while protection is off
		for (int i = 0; i < 8; i++)
		begin
			acc(KIND_FETCH, 32'(i) << 29, 1'b1, 1'b0);
			chk("default fetch", 32'(flt), 32'(8'he4 >> i) & 32'h1);
		end
		wr(REG_CTRL, 32'h1);
		for (int i = 0; i < 8; i++)
		begin
			wr(REG_REGION_BASE + 12'h004, 32'(attr_tab[i*5+:5]));
			acc(8'he0 >> i & 8'h1 ? KIND_LOAD : KIND_FETCH, 32'h2000_0010, 1'(8'hd9 >> i), 1'b0);
			chk("permission", 32'(flt), 32'(8'hba >> i) & 32'h1);
			chk("issued", 32'(sys_cnt - c0), 32'(!flt));
		end
		chk("fault kind", 32'(on_fetch), 32'h0);
		rdr(REG_FAULT_ADDR);
		chk("fault addr", rd, 32'h2000_0010);
		wr(REG_MASK, 32'h1);
		rdr(REG_STATUS);
		chk("status", rd, 32'h7);
		chk("irq on", 32'(irq), 32'h1);
		wr(REG_STATUS, 32'h1);
		rdr(REG_STATUS);
		chk("status cleared", rd, 32'h6);
		chk("irq off", 32'(irq), 32'h0);
		// Kinds 1..3 are explicit; maintenance never reaches memory
		for (int k = 0; k < 7; k++)
		begin
			acc(3'(k), 32'h0000_0100, 1'b1, 1'b0);
			chk("explicit", 32'(is_expl), 32'(k >= 1 && k <= 3));
			chk("issued", 32'(sys_cnt - c0), 32'(k != 6));
			if (k >= 1 && k <= 3)
				chk("read write", 32'({is_rd, is_wr}), 32'({k != 2, k == 2}));
		end
		wr(REG_REGION_BASE + 12'h004, 32'h0e);
		for (int j = 0; j < 2; j++)
		begin
			acc(KIND_LOAD, 32'(j) << 29 | 32'h200, 1'b1, 1'b1);
			acc(KIND_STORE, 32'(j) << 29 | 32'h200, 1'b1, 1'b1);
			chk("excl pass", 32'(excl_fail), 32'h0);
			chk("excl class", 32'({is_rd, is_wr}), 32'h3);
			acc(KIND_STORE, 32'(j) << 29 | 32'h200, 1'b1, 1'b1);
			chk("excl fail", 32'(excl_fail), 32'h1);
		end
		acc(KIND_LOAD, 32'h0000_0300, 1'b1, 1'b0);
		chk("load data", acc_rdata, ~32'h300);
		// Completion waits for fetch observers
		fork
			acc(KIND_LOAD, 32'h0000_0300, 1'b1, 1'b0);
			begin
				@(posedge core_clk);
				fetch_synced <= 1'b0;
				repeat (11) @(posedge core_clk);
				fetch_synced <= 1'b1;
			end
		join
		chk("sync wait", 32'(n >= 10), 32'h1);
		acc(KIND_LOAD, 32'he000_0000, 1'b1, 1'b0);
		chk("side pending", 32'(side_pending), 32'h1);
		chk("strong issue", 32'(sys_strong), 32'h1);
		rdr(REG_SIDE);
		chk("side reg", rd, 32'h1);
		side_visible <= 1'b1;
		@(posedge core_clk);
		side_visible <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("side clear", 32'(side_pending), 32'h0);
		summarize();
	end
endmodule

// *** testbench/link_properties.sv ***
`timescale 1ns/1ps
module link_properties
	import mem_order_pkg::*;
(
	input wire logic              CORE_CLK,     // Clock
	input wire logic              RST,          // Reset
	input wire logic              req_valid,    // Request
	input wire logic [ADDR_W-1:0] req_addr,     // Address
	input wire logic              req_write,    // Write
	input wire logic              req_explicit, // Ordered
	input wire logic              req_excl,     // Exclusive
	input wire logic              req_maint,    // Maintenance
	input wire logic              rsp_obs,      // Observed
	input wire logic              rsp_gobs,     // Global
	input wire logic              rsp_done,     // Complete
	input wire logic              rsp_excl_fail // Failed
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	logic gobs_seen_ff;
	// Global observation remembered until completion, cleared by it
	always_ff @(posedge CORE_CLK or posedge RST)
		if (RST)
			gobs_seen_ff <= 1'b0;
		else
			gobs_seen_ff <= (rsp_gobs || gobs_seen_ff) && !rsp_done;
	sequence s_pending;
		req_valid && !rsp_done;
	endsequence
	sequence s_finish;
		rsp_done ##1 !req_valid;
	endsequence
	a_req_held: assert property (s_pending |=> req_valid)
		else $error("request dropped before completion");
	a_addr_stable: assert property (s_pending |=> $stable(req_addr) && $stable(req_write))
		else $error("request changed while pending");
	a_done_ends: assert property (rsp_done |-> s_finish)
		else $error("request kept after completion");
	a_done_after_gobs: assert property (rsp_done |-> rsp_gobs || gobs_seen_ff)
		else $error("completion without global observation");
	a_gobs_has_obs: assert property (rsp_gobs |-> rsp_obs)
		else $error("global observation without observation");
	a_maint_quick: assert property ($rose(req_valid) && req_maint |=> rsp_done && rsp_gobs)
		else $error("maintenance completion late");
	a_maint_implicit: assert property (req_valid && req_maint |-> !req_explicit)
		else $error("maintenance marked explicit");
	a_idle_quiet: assert property (!req_valid |-> !rsp_done && !rsp_obs)
		else $error("response without request");
	a_excl_fail_store: assert property (rsp_done && rsp_excl_fail |-> req_excl && req_write)
		else $error("exclusive failure on non exclusive store");
	a_no_early_done: assert property ($rose(req_valid) && !req_maint && !req_excl |=> !rsp_done [*3])
		else $error("completion before memory acknowledge");
endmodule
